// ---- hdl/irfc_pkg.sv ----
package irfc_pkg;

   localparam int IRFC_DIM_W = 16;
   localparam int IRFC_REGIONS = 8;
   localparam int IRFC_IDX_W = 3;
   localparam int IRFC_ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] IRFC_OFS_ARRAY_COLUMNS = 8'h00;
   localparam logic [7:0] IRFC_OFS_ARRAY_ROWS = 8'h04;
   localparam logic [7:0] IRFC_OFS_BINNED_MAX_COLUMNS = 8'h08;
   localparam logic [7:0] IRFC_OFS_BINNED_MAX_ROWS = 8'h0c;
   localparam logic [7:0] IRFC_OFS_MULTI_REGION_MODE_ON = 8'h10;
   localparam logic [7:0] IRFC_OFS_REGION_INDEX = 8'h14;
   localparam logic [7:0] IRFC_OFS_REGION_ON = 8'h18;
   localparam logic [7:0] IRFC_OFS_REGION_COLUMNS = 8'h1c;
   localparam logic [7:0] IRFC_OFS_REGION_ROWS = 8'h20;
   localparam logic [7:0] IRFC_OFS_REGION_START_COL = 8'h24;
   localparam logic [7:0] IRFC_OFS_REGION_START_ROW = 8'h28;
   localparam logic [7:0] IRFC_OFS_REGION_OUTPUT_COUNT = 8'h2c;
   localparam logic [7:0] IRFC_OFS_REGION_SETUP_OK = 8'h30;
   localparam logic [7:0] IRFC_OFS_IMAGE_COLUMNS = 8'h34;
   localparam logic [7:0] IRFC_OFS_IMAGE_ROWS = 8'h38;
   localparam logic [7:0] IRFC_OFS_CROP_START_COL = 8'h3c;
   localparam logic [7:0] IRFC_OFS_CROP_START_ROW = 8'h40;
   localparam logic [7:0] IRFC_OFS_OUTPUT_ENCODING = 8'h44;
   localparam logic [7:0] IRFC_OFS_BITS_PER_SAMPLE = 8'h48;
   localparam logic [7:0] IRFC_OFS_MOSAIC_ARRANGEMENT = 8'h4c;
   localparam logic [7:0] IRFC_OFS_DARKEST_CODE = 8'h50;
   localparam logic [7:0] IRFC_OFS_HORIZONTAL_COMBINE_FACTOR = 8'h54;
   localparam logic [7:0] IRFC_OFS_VERTICAL_COMBINE_FACTOR = 8'h58;
   localparam logic [7:0] IRFC_OFS_EVENT_STATUS = 8'h5c;
   localparam logic [7:0] IRFC_OFS_EVENT_MASK = 8'h60;

   // Fixed values and reset values
   localparam logic [15:0] IRFC_ARRAY_COLUMNS = 16'h09a0;
   localparam logic [15:0] IRFC_ARRAY_ROWS = 16'h0808;
   localparam logic [31:0] IRFC_DARKEST_CODE = 32'h0000_0000;
   localparam logic [2:0] IRFC_RST_COMBINE = 3'h1;
   localparam logic [2:0] IRFC_COMBINE_MAX = 3'h4;
   localparam logic [5:0] IRFC_RST_ENCODING = 6'h00;
   localparam logic [5:0] IRFC_ENCODING_COUNT = 6'h2b;
   localparam logic [3:0] IRFC_SINGLE_COUNT = 4'h1;

   // Event status bit positions
   localparam int IRFC_EV_SETUP_BAD = 0;
   localparam int IRFC_EV_WRITE_REJECT = 1;
   localparam int IRFC_EV_W = 2;

   typedef struct packed {
      logic on;
      logic [IRFC_DIM_W-1:0] cols;
      logic [IRFC_DIM_W-1:0] rows;
      logic [IRFC_DIM_W-1:0] col0;
      logic [IRFC_DIM_W-1:0] row0;
   } irfc_region_s;

   typedef struct packed {
      logic on;
      logic cols;
      logic rows;
      logic col0;
      logic row0;
   } irfc_field_we_s;

   typedef struct packed {
      logic [IRFC_DIM_W-1:0] cols;
      logic [IRFC_DIM_W-1:0] rows;
      logic [IRFC_DIM_W-1:0] col0;
      logic [IRFC_DIM_W-1:0] row0;
   } irfc_window_s;

   typedef enum logic [2:0] {CFA_NONE, CFA_RG, CFA_GB, CFA_GR, CFA_BG} irfc_cfa_e;

   // Bits per pixel for each encoding code
   function automatic logic [6:0] irfc_bits_f(input logic [5:0] code);
      logic [6:0] b;
      b = 7'h00;
      case (code) inside
         6'h00, [6'h03:6'h06], 6'h27: b = 7'h08;
         [6'h01:6'h01], [6'h07:6'h0a], 6'h16, 6'h23, 6'h2a: b = 7'h10;
         6'h02, 6'h17, 6'h22, 6'h25: b = 7'h18;
         [6'h18:6'h1c], 6'h28: b = 7'h0a;
         [6'h0b:6'h15], [6'h1d:6'h21], 6'h24, 6'h29: b = 7'h0c;
         6'h26: b = 7'h20;
         default: b = 7'h00;
      endcase
      return b;
   endfunction

   // Mosaic for each encoding code
   function automatic irfc_cfa_e irfc_cfa_f(input logic [5:0] code);
      irfc_cfa_e c;
      c = CFA_NONE;
      case (code)
         6'h03, 6'h07, 6'h0c, 6'h11, 6'h19, 6'h1e: c = CFA_GR;
         6'h04, 6'h08, 6'h0d, 6'h12, 6'h1a, 6'h1f: c = CFA_RG;
         6'h05, 6'h09, 6'h0e, 6'h13, 6'h1b, 6'h20: c = CFA_GB;
         6'h06, 6'h0a, 6'h0f, 6'h14, 6'h1c, 6'h21: c = CFA_BG;
         default: c = CFA_NONE;
      endcase
      return c;
   endfunction

endpackage

// ---- hdl/irfc_region_mem.sv ----
`timescale 1ns/1ps
module irfc_region_mem import irfc_pkg::*; #(
   parameter int ENTRIES = IRFC_REGIONS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [IRFC_IDX_W-1:0] i_wr_idx,
   input wire irfc_field_we_s i_wr_en,
   input wire logic [IRFC_DIM_W-1:0] i_wr_data,
   input wire logic [IRFC_IDX_W-1:0] i_rd_idx_a,
   output irfc_region_s o_rd_a,
   input wire logic [IRFC_IDX_W-1:0] i_rd_idx_b,
   output irfc_region_s o_rd_b
);
   irfc_region_s mem_r [ENTRIES];
   irfc_region_s fwd_a;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++) begin : g_entry
         wire hit = (i_wr_idx == IRFC_IDX_W'(g));
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               mem_r[g] <= '0;
            end else if (hit) begin
               if (i_wr_en.on) mem_r[g].on <= i_wr_data[0];
               if (i_wr_en.cols) mem_r[g].cols <= i_wr_data;
               if (i_wr_en.rows) mem_r[g].rows <= i_wr_data;
               if (i_wr_en.col0) mem_r[g].col0 <= i_wr_data;
               if (i_wr_en.row0) mem_r[g].row0 <= i_wr_data;
            end
         end
      end
   endgenerate

   // Write-first view so a read right after a write sees the new value
   always_comb begin
      fwd_a = mem_r[i_rd_idx_a];
      if (i_wr_idx == i_rd_idx_a) begin
         if (i_wr_en.on) fwd_a.on = i_wr_data[0];
         if (i_wr_en.cols) fwd_a.cols = i_wr_data;
         if (i_wr_en.rows) fwd_a.rows = i_wr_data;
         if (i_wr_en.col0) fwd_a.col0 = i_wr_data;
         if (i_wr_en.row0) fwd_a.row0 = i_wr_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_a <= '0;
         o_rd_b <= '0;
      end else begin
         o_rd_a <= fwd_a;
         o_rd_b <= mem_r[i_rd_idx_b];
      end
   end
endmodule // irfc_region_mem

// ---- hdl/irfc_top.sv ----
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module irfc_top import irfc_pkg::*; (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [IRFC_ADDR_W-1:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   output logic O_IRQ,
   output logic O_MULTI_ON,
   output logic [IRFC_REGIONS-1:0] O_REGION_MASK,
   output irfc_window_s O_WIN,
   output logic [5:0] O_ENCODING
);
   typedef enum logic {SC_FILL, SC_RUN} irfc_scan_e;

   logic multi_on_r;
   logic [IRFC_IDX_W-1:0] region_index_r;
   logic [IRFC_DIM_W-1:0] image_cols_r, image_rows_r, crop_col_r, crop_row_r;
   logic [5:0] encoding_r;
   logic [2:0] hcomb_r, vcomb_r;
   logic [IRFC_EV_W-1:0] ev_status_r, ev_mask_r;
   logic [3:0] out_count_r, acc_count_r;
   logic setup_ok_r, acc_ok_r;
   logic [IRFC_REGIONS-1:0] acc_mask_r;
   logic [IRFC_IDX_W-1:0] scan_idx_r, chk_idx_r;
   irfc_scan_e scan_st_r;
   logic [31:0] rdata_nxt;
   logic [IRFC_DIM_W-1:0] max_cols, max_rows;
   irfc_region_s sel_rd, scan_rd;
   irfc_field_we_s field_we;

   // Bus decode
   wire wr_mode = I_WR && (I_ADDR == IRFC_OFS_MULTI_REGION_MODE_ON);
   wire wr_index = I_WR && (I_ADDR == IRFC_OFS_REGION_INDEX);
   wire wr_icols = I_WR && (I_ADDR == IRFC_OFS_IMAGE_COLUMNS);
   wire wr_irows = I_WR && (I_ADDR == IRFC_OFS_IMAGE_ROWS);
   wire wr_ccol = I_WR && (I_ADDR == IRFC_OFS_CROP_START_COL);
   wire wr_crow = I_WR && (I_ADDR == IRFC_OFS_CROP_START_ROW);
   wire wr_enc = I_WR && (I_ADDR == IRFC_OFS_OUTPUT_ENCODING);
   wire wr_hcomb = I_WR && (I_ADDR == IRFC_OFS_HORIZONTAL_COMBINE_FACTOR);
   wire wr_vcomb = I_WR && (I_ADDR == IRFC_OFS_VERTICAL_COMBINE_FACTOR);
   wire wr_status = I_WR && (I_ADDR == IRFC_OFS_EVENT_STATUS);
   wire wr_mask = I_WR && (I_ADDR == IRFC_OFS_EVENT_MASK);
   wire [IRFC_DIM_W-1:0] wdim = I_WDATA[IRFC_DIM_W-1:0];
   wire enc_ok = (I_WDATA < {26'h0, IRFC_ENCODING_COUNT});
   wire comb_ok = (I_WDATA != 32'h0) && (I_WDATA <= {29'h0, IRFC_COMBINE_MAX});
   wire reject = (wr_enc && !enc_ok) || ((wr_hcomb || wr_vcomb) && !comb_ok);
   wire [IRFC_IDX_W-1:0] index_nxt = wr_index ? I_WDATA[IRFC_IDX_W-1:0] : region_index_r;

   assign field_we.on = I_WR && (I_ADDR == IRFC_OFS_REGION_ON);
   assign field_we.cols = I_WR && (I_ADDR == IRFC_OFS_REGION_COLUMNS);
   assign field_we.rows = I_WR && (I_ADDR == IRFC_OFS_REGION_ROWS);
   assign field_we.col0 = I_WR && (I_ADDR == IRFC_OFS_REGION_START_COL);
   assign field_we.row0 = I_WR && (I_ADDR == IRFC_OFS_REGION_START_ROW);

   irfc_region_mem #(.ENTRIES(IRFC_REGIONS)) u_mem (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_wr_idx(region_index_r),
      .i_wr_en(field_we),
      .i_wr_data(wdim),
      .i_rd_idx_a(index_nxt),
      .o_rd_a(sel_rd),
      .i_rd_idx_b(scan_idx_r),
      .o_rd_b(scan_rd)
   );

   // Max size after combining; only the factors feed it
   always_comb begin
      case (hcomb_r)
         3'h2: max_cols = IRFC_ARRAY_COLUMNS / 16'h0002;
         3'h3: max_cols = IRFC_ARRAY_COLUMNS / 16'h0003;
         3'h4: max_cols = IRFC_ARRAY_COLUMNS / 16'h0004;
         default: max_cols = IRFC_ARRAY_COLUMNS;
      endcase
      case (vcomb_r)
         3'h2: max_rows = IRFC_ARRAY_ROWS / 16'h0002;
         3'h3: max_rows = IRFC_ARRAY_ROWS / 16'h0003;
         3'h4: max_rows = IRFC_ARRAY_ROWS / 16'h0004;
         default: max_rows = IRFC_ARRAY_ROWS;
      endcase
   end

   // Region check, one entry per cycle; a full pass takes eight cycles
   wire [IRFC_DIM_W:0] end_col = {1'b0, scan_rd.col0} + {1'b0, scan_rd.cols};
   wire [IRFC_DIM_W:0] end_row = {1'b0, scan_rd.row0} + {1'b0, scan_rd.rows};
   wire fits = (scan_rd.cols != '0) && (scan_rd.rows != '0)
      && (end_col <= {1'b0, max_cols}) && (end_row <= {1'b0, max_rows});
   wire ent_good = !scan_rd.on || fits;
   wire first = (chk_idx_r == '0);
   wire last = (scan_st_r == SC_RUN) && (chk_idx_r == IRFC_IDX_W'(IRFC_REGIONS - 1));
   wire [3:0] cnt_nxt = (first ? 4'h0 : acc_count_r) + {3'h0, scan_rd.on};
   wire ok_nxt = (first ? 1'b1 : acc_ok_r) && ent_good;
   wire setup_ok_nxt = ok_nxt && (cnt_nxt != 4'h0);
   wire [IRFC_REGIONS-1:0] bit_sel = IRFC_REGIONS'(1) << chk_idx_r;
   wire [IRFC_REGIONS-1:0] mask_nxt = (first ? '0 : acc_mask_r) | (scan_rd.on ? bit_sel : '0);
   wire [3:0] count_view = multi_on_r ? out_count_r : IRFC_SINGLE_COUNT;

   // Events: setup turning invalid in multi mode, and a rejected write
   wire ev_bad = last && multi_on_r && setup_ok_r && !setup_ok_nxt;
   wire [IRFC_EV_W-1:0] ev_set = {reject, ev_bad};
   wire [IRFC_EV_W-1:0] ev_clr = wr_status ? I_WDATA[IRFC_EV_W-1:0] : '0;
   wire [IRFC_EV_W-1:0] ev_status_nxt = (ev_status_r & ~ev_clr) | ev_set;

   // Read mux
   always_comb begin
      rdata_nxt = 32'h0;
      case (I_ADDR)
         IRFC_OFS_ARRAY_COLUMNS: rdata_nxt = {16'h0, IRFC_ARRAY_COLUMNS};
         IRFC_OFS_ARRAY_ROWS: rdata_nxt = {16'h0, IRFC_ARRAY_ROWS};
         IRFC_OFS_BINNED_MAX_COLUMNS: rdata_nxt = {16'h0, max_cols};
         IRFC_OFS_BINNED_MAX_ROWS: rdata_nxt = {16'h0, max_rows};
         IRFC_OFS_MULTI_REGION_MODE_ON: rdata_nxt = {31'h0, multi_on_r};
         IRFC_OFS_REGION_INDEX: rdata_nxt = {29'h0, region_index_r};
         IRFC_OFS_REGION_ON: rdata_nxt = {31'h0, sel_rd.on};
         IRFC_OFS_REGION_COLUMNS: rdata_nxt = {16'h0, sel_rd.cols};
         IRFC_OFS_REGION_ROWS: rdata_nxt = {16'h0, sel_rd.rows};
         IRFC_OFS_REGION_START_COL: rdata_nxt = {16'h0, sel_rd.col0};
         IRFC_OFS_REGION_START_ROW: rdata_nxt = {16'h0, sel_rd.row0};
         IRFC_OFS_REGION_OUTPUT_COUNT: rdata_nxt = {28'h0, count_view};
         IRFC_OFS_REGION_SETUP_OK: rdata_nxt = {31'h0, setup_ok_r};
         IRFC_OFS_IMAGE_COLUMNS: rdata_nxt = {16'h0, image_cols_r};
         IRFC_OFS_IMAGE_ROWS: rdata_nxt = {16'h0, image_rows_r};
         IRFC_OFS_CROP_START_COL: rdata_nxt = {16'h0, crop_col_r};
         IRFC_OFS_CROP_START_ROW: rdata_nxt = {16'h0, crop_row_r};
         IRFC_OFS_OUTPUT_ENCODING: rdata_nxt = {26'h0, encoding_r};
         IRFC_OFS_BITS_PER_SAMPLE: rdata_nxt = {25'h0, irfc_bits_f(encoding_r)};
         IRFC_OFS_MOSAIC_ARRANGEMENT: rdata_nxt = {29'h0, irfc_cfa_f(encoding_r)};
         IRFC_OFS_DARKEST_CODE: rdata_nxt = IRFC_DARKEST_CODE;
         IRFC_OFS_HORIZONTAL_COMBINE_FACTOR: rdata_nxt = {29'h0, hcomb_r};
         IRFC_OFS_VERTICAL_COMBINE_FACTOR: rdata_nxt = {29'h0, vcomb_r};
         IRFC_OFS_EVENT_STATUS: rdata_nxt = {30'h0, ev_status_r};
         IRFC_OFS_EVENT_MASK: rdata_nxt = {30'h0, ev_mask_r};
         default: rdata_nxt = 32'h0;
      endcase
   end

   // Control registers
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         multi_on_r <= 1'b0;
         region_index_r <= '0;
         image_cols_r <= IRFC_ARRAY_COLUMNS;
         image_rows_r <= IRFC_ARRAY_ROWS;
         crop_col_r <= '0;
         crop_row_r <= '0;
      end else begin
         if (wr_mode) multi_on_r <= I_WDATA[0];
         region_index_r <= index_nxt;
         if (wr_icols) image_cols_r <= wdim;
         if (wr_irows) image_rows_r <= wdim;
         if (wr_ccol) crop_col_r <= wdim;
         if (wr_crow) crop_row_r <= wdim;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         encoding_r <= IRFC_RST_ENCODING;
         hcomb_r <= IRFC_RST_COMBINE;
         vcomb_r <= IRFC_RST_COMBINE;
         ev_status_r <= '0;
         ev_mask_r <= '0;
      end else begin
         if (wr_enc && enc_ok) encoding_r <= I_WDATA[5:0];
         if (wr_hcomb && comb_ok) hcomb_r <= I_WDATA[2:0];
         if (wr_vcomb && comb_ok) vcomb_r <= I_WDATA[2:0];
         ev_status_r <= ev_status_nxt;
         if (wr_mask) ev_mask_r <= I_WDATA[IRFC_EV_W-1:0];
      end
   end

   // Scanner
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         scan_st_r <= SC_FILL;
         scan_idx_r <= '0;
         chk_idx_r <= '0;
         acc_count_r <= '0;
         acc_ok_r <= 1'b0;
         acc_mask_r <= '0;
         out_count_r <= '0;
         setup_ok_r <= 1'b0;
      end else begin
         scan_idx_r <= scan_idx_r + IRFC_IDX_W'(1);
         chk_idx_r <= scan_idx_r;
         case (scan_st_r)
            SC_FILL: scan_st_r <= SC_RUN;
            SC_RUN: scan_st_r <= SC_RUN;
            default: scan_st_r <= SC_FILL;
         endcase
         acc_count_r <= cnt_nxt;
         acc_ok_r <= ok_nxt;
         acc_mask_r <= mask_nxt;
         if (last) begin
            out_count_r <= cnt_nxt;
            setup_ok_r <= setup_ok_nxt;
         end
      end
   end

   // Outputs
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= 32'h0;
         O_IRQ <= 1'b0;
         O_MULTI_ON <= 1'b0;
         O_REGION_MASK <= '0;
         O_WIN <= '0;
         O_ENCODING <= IRFC_RST_ENCODING;
      end else begin
         O_RDATA <= I_RD ? rdata_nxt : 32'h0;
         O_IRQ <= |(ev_status_nxt & ev_mask_r);
         O_MULTI_ON <= multi_on_r;
         if (last) O_REGION_MASK <= multi_on_r ? mask_nxt : '0;
         O_WIN <= {image_cols_r, image_rows_r, crop_col_r, crop_row_r};
         O_ENCODING <= encoding_r;
      end
   end

   // Checks
   array_cols_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_ARRAY_COLUMNS |=> O_RDATA == 32'h0000_09a0)
      else $error("array columns wrong");
   array_rows_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_ARRAY_ROWS |=> O_RDATA == 32'h0000_0808)
      else $error("array rows wrong");
   max_cols_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (wr_icols || wr_ccol) && !wr_hcomb |=> $stable(max_cols))
      else $error("max columns moved with region");
   max_rows_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (wr_irows || wr_crow) && !wr_vcomb |=> $stable(max_rows))
      else $error("max rows moved with region");
   mode_bit_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_mode |-> ##2 O_MULTI_ON == $past(I_WDATA[0], 2))
      else $error("mode bit not applied");
   region_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_REGION_INDEX |=> O_RDATA[31:3] == '0)
      else $error("region index wide");
   region_on_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      field_we.on ##1 (I_RD && I_ADDR == IRFC_OFS_REGION_ON && !wr_index)
      |=> O_RDATA == {31'h0, $past(I_WDATA[0], 2)})
      else $error("region on readback");
   region_cols_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      field_we.cols ##1 (I_RD && I_ADDR == IRFC_OFS_REGION_COLUMNS && !wr_index)
      |=> O_RDATA == {16'h0, $past(wdim, 2)})
      else $error("region columns readback");
   region_col0_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      field_we.col0 ##1 (I_RD && I_ADDR == IRFC_OFS_REGION_START_COL && !wr_index)
      |=> O_RDATA == {16'h0, $past(wdim, 2)})
      else $error("region start column readback");
   single_count_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_REGION_OUTPUT_COUNT && !multi_on_r |=> O_RDATA == 32'h1)
      else $error("single count not one");
   setup_bad_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      last && !ok_nxt |=> !setup_ok_r && out_count_r == $past(cnt_nxt))
      else $error("setup flag kept");
   single_win_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_icols |-> ##2 O_WIN.cols == $past(wdim, 2))
      else $error("window width not applied");
   single_org_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_crow |-> ##2 O_WIN.row0 == $past(wdim, 2))
      else $error("window row offset not applied");
   enc_keep_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_enc && !enc_ok |=> $stable(encoding_r) && ev_status_r[IRFC_EV_WRITE_REJECT])
      else $error("bad encoding accepted");
   bits_range_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_BITS_PER_SAMPLE |=> O_RDATA inside {[32'h1:32'h60]})
      else $error("bits per pixel out of range");
   mosaic_none_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_MOSAIC_ARRANGEMENT && encoding_r inside {6'h00, 6'h01, 6'h02}
      |=> O_RDATA == 32'h0)
      else $error("mosaic for non-Bayer");
   darkest_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_RD && I_ADDR == IRFC_OFS_DARKEST_CODE |=> O_RDATA == 32'h0)
      else $error("darkest code not zero");
   comb_one_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      hcomb_r == 3'h1 |-> max_cols == 16'h09a0)
      else $error("max columns not array width");
   irq_level_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      $stable(ev_mask_r) |-> O_IRQ == |(ev_status_r & ev_mask_r))
      else $error("interrupt level wrong");

   multi_full_c: cover property (@(posedge I_CLK) disable iff (I_RST)
      last && multi_on_r && setup_ok_nxt && cnt_nxt == 4'h8);
   setup_bad_c: cover property (@(posedge I_CLK) disable iff (I_RST) ev_bad);
   reject_c: cover property (@(posedge I_CLK) disable iff (I_RST) reject ##[1:20] O_IRQ);
   bayer_c: cover property (@(posedge I_CLK) disable iff (I_RST) irfc_cfa_f(encoding_r) == CFA_BG);
endmodule // irfc_top

// ---- testbench/test_irfc_top.sv ----
`timescale 1ns/1ps
module test_irfc_top import irfc_pkg::*; ;
   logic I_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic [7:0] I_ADDR = 8'h00;
   logic [31:0] I_WDATA = 32'h0;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic [31:0] O_RDATA;
   logic O_IRQ, O_MULTI_ON;
   logic [7:0] O_REGION_MASK;
   irfc_window_s O_WIN;
   logic [5:0] O_ENCODING;
   int n_fail = 0;
   int check_count = 0;
   integer seed = 32'ha47a3337;
   logic [31:0] exp_q[$];
   logic [7:0] adr_q[$];
   logic rd_d = 1'b0;
   logic [15:0] rg[8][4];
   logic [15:0] w[4];
   int bpp[43] = '{8, 16, 24, 8, 8, 8, 8, 16, 16, 16, 16, 12, 12, 12, 12, 12, 12, 12, 12, 12, 12,
      12, 16, 24, 10, 10, 10, 10, 10, 12, 12, 12, 12, 12, 24, 16, 12, 24, 32, 8, 10, 12, 16};
   int ra[14] = '{0, 4, 8, 12, 52, 56, 80, 68, 44, 84, 88, 92, 96, 252};
   int rv[14] = '{2464, 2056, 2464, 2056, 2464, 2056, 0, 0, 1, 1, 1, 0, 0, 0};
   irfc_top u_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_MULTI_ON(O_MULTI_ON),
      .O_REGION_MASK(O_REGION_MASK), .O_WIN(O_WIN), .O_ENCODING(O_ENCODING));
   initial begin
      forever #12.5 I_CLK = ~I_CLK;
   end
   function automatic logic [31:0] cfa(int c);
      int s[6] = '{3, 7, 12, 17, 25, 30};
      int m[4] = '{3, 1, 2, 4};
      cfa = 32'h0;
      foreach (s[i]) if (c >= s[i] && c < s[i] + 4) cfa = m[c-s[i]];
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge I_CLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge I_CLK);
      I_RD <= 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED reg %h exp %h got %h", a, e, g);
      end
   endtask
   task automatic chk_out(input string n, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   always @(posedge I_CLK) rd_d <= I_RD;
   always @(negedge I_CLK) begin
      if (rd_d) chk_rd(adr_q.pop_front(), exp_q.pop_front(), O_RDATA);
   end
   initial begin
      repeat (20000) @(posedge I_CLK);
      $display("watchdog expired");
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge I_CLK);
      I_RST <= 1'b0;
      foreach (ra[i]) rd(ra[i][7:0], rv[i]);
      @(negedge I_CLK);
      chk_out("win", {16'd2464, 16'd2056, 32'h0}, O_WIN);
      wr(8'h00, $random(seed));
      rd(8'h00, 32'd2464);
      $display("reset values done");
      wr(8'h60, 32'h3);
      for (int f = 4; f > 0; f--) begin
         wr(8'h54, f);
         wr(8'h58, f);
         wr(8'h34, $random(seed) & 32'hffff);
         rd(8'h08, 2464 / f);
         rd(8'h0c, 2056 / f);
      end
      wr(8'h54, 32'h0);
      rd(8'h54, 32'h1);
      rd(8'h5c, 32'h2);
      @(negedge I_CLK);
      chk_out("irq", 64'h1, O_IRQ);
      wr(8'h5c, 32'h2);
      rd(8'h5c, 32'h0);
      @(negedge I_CLK);
      chk_out("irq", 64'h0, O_IRQ);
      $display("combine factors done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h14, i);
         wr(8'h18, !i[0]);
         for (int j = 0; j < 4; j++) begin
            rg[i][j] = ($random(seed) & 63) + (j < 2);
            wr(8'h1c + 8'(4 * j), rg[i][j]);
         end
      end
      for (int i = 7; i >= 0; i--) begin
         wr(8'h14, i);
         rd(8'h18, !i[0]);
         for (int j = 0; j < 4; j++) rd(8'h1c + 8'(4 * j), rg[i][j]);
      end
      wr(8'h10, 32'h1);
      repeat (20) @(posedge I_CLK);
      rd(8'h2c, 32'h4);
      rd(8'h30, 32'h1);
      @(negedge I_CLK);
      chk_out("mode", 64'h155, {O_MULTI_ON, O_REGION_MASK});
      wr(8'h14, 32'h0);
      wr(8'h24, 32'd2464);
      repeat (20) @(posedge I_CLK);
      rd(8'h30, 32'h0);
      rd(8'h5c, 32'h1);
      wr(8'h5c, 32'h1);
      rd(8'h5c, 32'h0);
      $display("regions done");
      wr(8'h10, 32'h0);
      for (int j = 0; j < 4; j++) begin
         w[j] = $random(seed);
         wr(8'h34 + 8'(4 * j), w[j]);
      end
      repeat (20) @(posedge I_CLK);
      rd(8'h2c, 32'h1);
      @(negedge I_CLK);
      chk_out("win", {w[0], w[1], w[2], w[3]}, O_WIN);
      $display("single region done");
      for (int c = 0; c < 43; c++) begin
         wr(8'h44, c);
         rd(8'h48, bpp[c]);
         rd(8'h4c, cfa(c));
      end
      wr(8'h44, 32'd43);
      rd(8'h44, 32'd42);
      @(negedge I_CLK);
      chk_out("enc", 64'd42, O_ENCODING);
      repeat (3) @(posedge I_CLK);
      if (exp_q.size() != 0) n_fail++;
      $display("encodings done");
      complete_run();
   end
endmodule // test_irfc_top
